// File: rosc_ctrl.sv
// Purpose: register and control logic around an eight-stage ring oscillator
// Assumes: mclk stands in for the oscillator edge; ring pins are analog side
// Notes: AXI4-Lite slave, one write and one read in flight
`timescale 1ns/1ps
`include "rosc_consts.svh"
module rosc_ctrl import rosc_pkg::*; #(
  parameter int DIV_W = 8
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // AXI4-Lite write
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [31:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Ring side
  input wire logic wake_irq_in,
  input wire logic ring_sample_in,
  output rosc_ring_t ring_ctrl,
  output logic ring_clock_out,
  output logic ring_clock_out_shifted
);
  localparam int WAKE_MAX = `ROSC_WAKE_CYC + 2;

  logic aw_hold_reg, w_hold_reg, bvalid_reg, rvalid_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg, rdata_reg;
  logic [3:0] wstrb_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [11:0] enable_reg, range_reg;
  logic [23:0] drive_reg;
  logic [15:0] key_a_reg, key_b_reg;
  logic [31:0] pause_reg;
  logic [DIV_W-1:0] div_reg, cur_div_reg, cnt_reg;
  logic [3:0] phase_reg;
  logic [15:0] hist_reg;
  logic badwr_reg, clk_raw_reg, clk_main_reg, clk_ph_reg;
  logic [7:0] count_reg;
  logic [7:0] wake_cnt_reg;
  logic wake_s1_reg, wake_s2_reg, rnd_s1_reg, rnd_s2_reg;
  rosc_state_t st_reg;
  logic wr_fire, rd_fire, enabled, osc_on, stable;
  logic [31:0] wval;
  logic [DIV_W-1:0] div_eff;

  function automatic logic mapped(input logic [7:0] a);
    return a == `ROSC_OFF_CTRL || a == `ROSC_OFF_DRVA || a == `ROSC_OFF_DRVB ||
      a == `ROSC_OFF_PAUSE || a == `ROSC_OFF_DIV || a == `ROSC_OFF_PHASE ||
      a == `ROSC_OFF_STATUS || a == `ROSC_OFF_RAND || a == `ROSC_OFF_COUNT;
  endfunction

  function automatic logic [31:0] unpack_ds(input logic [11:0] d, input logic [15:0] k);
    return {k, 1'b0, d[11:9], 1'b0, d[8:6], 1'b0, d[5:3], 1'b0, d[2:0]};
  endfunction

  function automatic logic [11:0] pack_ds(input logic [31:0] v);
    // A wrong key zeroes all four stages of the half written rather than keeping the old setting
    if (v[31:16] != `ROSC_DRIVE_KEY) begin
      return 12'h000;
    end
    return {v[14:12], v[10:8], v[6:4], v[2:0]};
  endfunction

  function automatic logic [31:0] reg_val(input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0;
    if (a == `ROSC_OFF_CTRL) begin
      v = {8'h00, enable_reg, range_reg};
    end else if (a == `ROSC_OFF_DRVA) begin
      v = unpack_ds(drive_reg[11:0], key_a_reg);
    end else if (a == `ROSC_OFF_DRVB) begin
      v = unpack_ds(drive_reg[23:12], key_b_reg);
    end else if (a == `ROSC_OFF_PAUSE) begin
      v = pause_reg;
    end else if (a == `ROSC_OFF_DIV) begin
      v[DIV_W-1:0] = div_reg;
    end else if (a == `ROSC_OFF_PHASE) begin
      v[3:0] = phase_reg;
    end else if (a == `ROSC_OFF_STATUS) begin
      v[`ROSC_ST_STABLE] = stable;
      v[`ROSC_ST_BADWR] = badwr_reg;
      v[`ROSC_ST_ENABLED] = enabled;
    end else if (a == `ROSC_OFF_RAND) begin
      v[0] = rnd_s2_reg;
    end else if (a == `ROSC_OFF_COUNT) begin
      v[7:0] = count_reg;
    end
    return v;
  endfunction

  // Bus handshakes
  assign awready = !aw_hold_reg && !bvalid_reg;
  assign wready = !w_hold_reg && !bvalid_reg;
  assign arready = !rvalid_reg;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;
  assign wr_fire = aw_hold_reg && w_hold_reg && !bvalid_reg;
  assign rd_fire = arvalid && arready;

  always_comb begin
    wval = reg_val(awaddr_reg);
    for (int i = 0; i < 4; i++) begin
      if (wstrb_reg[i]) begin
        wval[i*8 +: 8] = wdata_reg[i*8 +: 8];
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0;
      wstrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `ROSC_RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_hold_reg <= 1'b1;
        awaddr_reg <= awaddr[7:0];
      end
      if (wvalid && wready) begin
        w_hold_reg <= 1'b1;
        wdata_reg <= wdata;
        wstrb_reg <= wstrb;
      end
      if (wr_fire) begin
        aw_hold_reg <= 1'b0;
        w_hold_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= mapped(awaddr_reg) ? `ROSC_RESP_OKAY : `ROSC_RESP_SLVERR;
      end else if (bvalid_reg && bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0;
      rresp_reg <= `ROSC_RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= reg_val(araddr[7:0]);
      rresp_reg <= mapped(araddr[7:0]) ? `ROSC_RESP_OKAY : `ROSC_RESP_SLVERR;
    end else if (rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // Control registers
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      enable_reg <= `ROSC_EN_ENABLE;
      range_reg <= `ROSC_RANGE_RESET;
      drive_reg <= 24'h0;
      key_a_reg <= 16'h0;
      key_b_reg <= 16'h0;
      div_reg <= DIV_W'(`ROSC_DIV_RESET);
      phase_reg <= 4'h0;
    end else if (wr_fire) begin
      if (awaddr_reg == `ROSC_OFF_CTRL) begin
        enable_reg <= wval[23:12];
        range_reg <= wval[11:0];
      end else if (awaddr_reg == `ROSC_OFF_DRVA) begin
        key_a_reg <= wval[31:16];
        drive_reg[11:0] <= pack_ds(wval);
      end else if (awaddr_reg == `ROSC_OFF_DRVB) begin
        key_b_reg <= wval[31:16];
        drive_reg[23:12] <= pack_ds(wval);
      end else if (awaddr_reg == `ROSC_OFF_DIV) begin
        div_reg <= wval[DIV_W-1:0];
      end else if (awaddr_reg == `ROSC_OFF_PHASE) begin
        phase_reg <= wval[3:0];
      end
    end
  end

  // Sticky bad-write flag; a new bad write beats a clear in the same cycle
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      badwr_reg <= 1'b0;
    end else if (wr_fire && ((awaddr_reg == `ROSC_OFF_CTRL &&
        ((wval[23:12] != `ROSC_EN_ENABLE && wval[23:12] != `ROSC_EN_DISABLE) ||
        (wval[11:0] != `ROSC_RANGE_LOW && wval[11:0] != `ROSC_RANGE_MED &&
        wval[11:0] != `ROSC_RANGE_HIGH && wval[11:0] != `ROSC_RANGE_OVER))) ||
        (awaddr_reg == `ROSC_OFF_PAUSE && wval != `ROSC_PAUSE_KEY &&
        wval != `ROSC_WAKE_KEY))) begin
      badwr_reg <= 1'b1;
    end else if (wr_fire && awaddr_reg == `ROSC_OFF_STATUS && wval[`ROSC_ST_BADWR]) begin
      badwr_reg <= 1'b0;
    end
  end

  // Ring controls; an invalid range code keeps the full eight-stage loop
  assign enabled = enable_reg != `ROSC_EN_DISABLE;
  assign osc_on = enabled && st_reg != ST_PAUSED;
  always_comb begin
    ring_ctrl.enable = osc_on;
    ring_ctrl.drive = drive_reg;
    case (range_reg)
      `ROSC_RANGE_MED: ring_ctrl.loop_length_select = LEN_SIX;
      `ROSC_RANGE_HIGH: ring_ctrl.loop_length_select = LEN_FOUR;
      `ROSC_RANGE_OVER: ring_ctrl.loop_length_select = LEN_TWO;
      default: ring_ctrl.loop_length_select = LEN_EIGHT;
    endcase
  end

  // Synchronisers for the wake line and the ring sample
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wake_s1_reg <= 1'b0;
      wake_s2_reg <= 1'b0;
      rnd_s1_reg <= 1'b0;
      rnd_s2_reg <= 1'b0;
    end else begin
      wake_s1_reg <= wake_irq_in;
      wake_s2_reg <= wake_s1_reg;
      rnd_s1_reg <= ring_sample_in;
      rnd_s2_reg <= rnd_s1_reg;
    end
  end

  // Pause key register; a wake or any invalid write selects the wake code
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pause_reg <= `ROSC_WAKE_KEY;
    end else if (wr_fire && awaddr_reg == `ROSC_OFF_PAUSE) begin
      pause_reg <= (wval == `ROSC_PAUSE_KEY) ? `ROSC_PAUSE_KEY : `ROSC_WAKE_KEY;
    end else if (st_reg == ST_PAUSED && wake_s2_reg) begin
      pause_reg <= `ROSC_WAKE_KEY;
    end
  end

  // Oscillator state: start-up, running, paused
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= ST_START;
      wake_cnt_reg <= 8'h00;
    end else begin
      case (st_reg)
        ST_START: begin
          // A pause key written during start-up must still stop the ring
          if (pause_reg == `ROSC_PAUSE_KEY) begin
            st_reg <= ST_PAUSED;
          end else if (!enabled) begin
            wake_cnt_reg <= 8'h00;
          end else if (wake_cnt_reg >= 8'(`ROSC_WAKE_CYC - 1)) begin
            st_reg <= ST_RUN;
          end else begin
            wake_cnt_reg <= wake_cnt_reg + 8'h01;
          end
        end
        ST_RUN: begin
          wake_cnt_reg <= 8'h00;
          if (pause_reg == `ROSC_PAUSE_KEY) begin
            st_reg <= ST_PAUSED;
          end else if (!enabled) begin
            st_reg <= ST_START;
          end
        end
        default: begin
          // Without a wake line this state is never left
          wake_cnt_reg <= 8'h00;
          if (wake_s2_reg) begin
            st_reg <= ST_START;
          end
        end
      endcase
    end
  end
  assign stable = st_reg == ST_RUN;

  // Countdown at the oscillator rate; it freezes while the ring is stopped
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      count_reg <= 8'h00;
    end else if (wr_fire && awaddr_reg == `ROSC_OFF_COUNT) begin
      count_reg <= wval[7:0];
    end else if (osc_on && count_reg != 8'h00) begin
      count_reg <= count_reg - 8'h01;
    end
  end

  // Divider: a new divisor is taken only at a period boundary
  assign div_eff = (div_reg == '0) ? DIV_W'(1) : div_reg;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cnt_reg <= '0;
      cur_div_reg <= DIV_W'(`ROSC_DIV_RESET);
    end else if (osc_on) begin
      if (cnt_reg >= cur_div_reg - DIV_W'(1)) begin
        cnt_reg <= '0;
        cur_div_reg <= div_eff;
      end else begin
        cnt_reg <= cnt_reg + DIV_W'(1);
      end
    end
  end

  // Divide by one holds the output high; only even divisors give 50 percent
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      clk_raw_reg <= 1'b0;
      clk_main_reg <= 1'b0;
      clk_ph_reg <= 1'b0;
      hist_reg <= 16'h0;
    end else begin
      clk_raw_reg <= {1'b0, cnt_reg} < (({1'b0, cur_div_reg} + 1'b1) >> 1);
      hist_reg <= {hist_reg[14:0], clk_raw_reg};
      clk_main_reg <= clk_raw_reg;
      clk_ph_reg <= (phase_reg == 4'h0) ? clk_raw_reg : hist_reg[phase_reg - 4'h1];
    end
  end
  assign ring_clock_out = clk_main_reg;
  assign ring_clock_out_shifted = clk_ph_reg;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);

  chk_range_high: assert property (range_reg == `ROSC_RANGE_HIGH |->
    ring_ctrl.loop_length_select == LEN_FOUR)
    else $error("high range not four stages");
  chk_range_invalid: assert property (range_reg == `ROSC_RANGE_RESET |->
    ring_ctrl.loop_length_select == LEN_EIGHT)
    else $error("reset range code not eight stages");
  chk_drive_key: assert property (wr_fire && awaddr_reg == `ROSC_OFF_DRVA &&
    wval[31:16] != `ROSC_DRIVE_KEY |=> drive_reg[11:0] == 12'h000)
    else $error("drive applied without key");
  chk_disable_code: assert property (enable_reg == `ROSC_EN_ENABLE + 12'h001 |->
    enabled)
    else $error("invalid enable code stopped ring");
  chk_div_boundary: assert property ($changed(cur_div_reg) |-> cnt_reg == '0)
    else $error("divisor changed mid period");
  chk_phase_zero: assert property (phase_reg == 4'h0 && $past(phase_reg) == 4'h0 |->
    ring_clock_out == ring_clock_out_shifted)
    else $error("outputs differ at zero phase");
  chk_count_step: assert property (osc_on && count_reg != 8'h00 &&
    !(wr_fire && awaddr_reg == `ROSC_OFF_COUNT) |=> count_reg == $past(count_reg) - 8'h01)
    else $error("countdown did not step");
  chk_count_stop: assert property (count_reg == 8'h00 && !wr_fire |=> count_reg == 8'h00)
    else $error("countdown left zero");
  chk_pause_stop: assert property (wr_fire && awaddr_reg == `ROSC_OFF_PAUSE &&
    wval == `ROSC_PAUSE_KEY && stable |=> ##1 !ring_ctrl.enable)
    else $error("pause key did not stop ring");
  chk_wake_time: assert property (st_reg == ST_PAUSED ##1 st_reg == ST_START && enabled
    |-> enabled throughout ##[1:WAKE_MAX] stable)
    else $error("ring not stable in time after wake");
  chk_rand_bit: assert property (rd_fire && araddr[7:0] == `ROSC_OFF_RAND |=>
    rdata == {31'h0, $past(rnd_s2_reg)})
    else $error("random read wrong");
  cov_pause_wake: cover property (st_reg == ST_PAUSED ##[1:50] stable);
  cov_div_change: cover property (cnt_reg == '0 && $changed(cur_div_reg));
  cov_count_zero: cover property (count_reg == 8'h01 ##1 count_reg == 8'h00);
endmodule

// File: rosc_consts.svh
// Purpose: register map, field layout, reset values and timing counts
// Assumes: AXI4-Lite byte addresses, 32-bit words
// Notes: definitions only
`ifndef ROSC_CONSTS_SVH
`define ROSC_CONSTS_SVH
`define ROSC_OFF_CTRL 8'h00
`define ROSC_OFF_DRVA 8'h04
`define ROSC_OFF_DRVB 8'h08
`define ROSC_OFF_PAUSE 8'h0C
`define ROSC_OFF_DIV 8'h10
`define ROSC_OFF_PHASE 8'h14
`define ROSC_OFF_STATUS 8'h18
`define ROSC_OFF_RAND 8'h1C
`define ROSC_OFF_COUNT 8'h20
`define ROSC_EN_DISABLE 12'hD1E
`define ROSC_EN_ENABLE 12'hFAB
`define ROSC_RANGE_LOW 12'hFA4
`define ROSC_RANGE_MED 12'hFA5
`define ROSC_RANGE_HIGH 12'hFA7
`define ROSC_RANGE_OVER 12'hFA6
`define ROSC_RANGE_RESET 12'hAA0
`define ROSC_DRIVE_KEY 16'h9696
`define ROSC_PAUSE_KEY 32'h636F6D61
`define ROSC_WAKE_KEY 32'h77616B65
`define ROSC_DIV_RESET 8'h10
`define ROSC_ST_STABLE 31
`define ROSC_ST_BADWR 24
`define ROSC_ST_ENABLED 12
`define ROSC_CLK_PERIOD_NS 50
`define ROSC_WAKE_TIME_NS 1000
`define ROSC_WAKE_CYC (`ROSC_WAKE_TIME_NS / `ROSC_CLK_PERIOD_NS)
`define ROSC_RESP_OKAY 2'h0
`define ROSC_RESP_SLVERR 2'h2
`endif

// File: rosc_pkg.sv
// Purpose: shared types of the ring oscillator control
// Assumes: constants live in rosc_consts.svh
// Notes: none
package rosc_pkg;
  typedef enum logic [1:0] {LEN_EIGHT, LEN_SIX, LEN_FOUR, LEN_TWO} rosc_len_t;
  typedef struct packed {
    logic enable;
    rosc_len_t loop_length_select;
    logic [23:0] drive;
  } rosc_ring_t;
  typedef enum logic [1:0] {ST_START, ST_RUN, ST_PAUSED} rosc_state_t;
endpackage

// File: rosc_tb.sv
// Purpose: self-checking bench for the ring oscillator control block
// Assumes: bench acts as AXI4-Lite master and drives the ring tap and wake line
// Notes: assertions live in the design; reads add an idle edge so no signal is set twice
`timescale 1ns/1ps
`include "rosc_consts.svh"
module tb import rosc_pkg::*;;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic wake_irq_in = 1'b0, ring_sample_in = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, ring_clock_out, ring_clock_out_shifted;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, v;
  rosc_ring_t ring_ctrl;
  int err_total = 0, check_count = 0, cyc = 0, p, t0, n;
  logic [11:0] codes[4] = '{`ROSC_RANGE_LOW, `ROSC_RANGE_MED, `ROSC_RANGE_HIGH, `ROSC_RANGE_OVER};
  rosc_len_t lens[4] = '{LEN_EIGHT, LEN_SIX, LEN_FOUR, LEN_TWO};
  int dv[3] = '{2, 5, 9};

  always #25 mclk = ~mclk;
  always @(posedge mclk) cyc <= cyc + 1;

  rosc_ctrl #(.DIV_W(8)) dut_u (.mclk(mclk), .rstn(rstn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .wake_irq_in(wake_irq_in), .ring_sample_in(ring_sample_in), .ring_ctrl(ring_ctrl),
    .ring_clock_out(ring_clock_out), .ring_clock_out_shifted(ring_clock_out_shifted));

  task automatic conclude();
    $display("checks %0d, mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string msg);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: response %h expected %h", $time, got, exp);
    end
  endtask

  task automatic hang(input string msg);
    err_total++;
    $display("unexpected at %0t: %s wait ran out", $time, msg);
    conclude();
  endtask

  // Called just after a rising edge; ends one edge after the response
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    int k;
    awaddr <= {24'h0, a};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge mclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        resp = bresp;
        bready <= 1'b0;
        break;
      end
    end
    if (k == 50) hang("write");
    @(posedge mclk);
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    int k;
    araddr <= {24'h0, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge mclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
        break;
      end
    end
    if (k == 50) hang("read");
    @(posedge mclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    axi_wr(a, d, r);
    chk_resp(r, `ROSC_RESP_OKAY);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    axi_rd(a, v, r);
    chk_resp(r, `ROSC_RESP_OKAY);
    chk_word(v, exp, "register read");
  endtask

  // Cycles from one rise of the divided clock to the next
  task automatic period(output int per);
    int k, s;
    logic last;
    s = -1;
    last = ring_clock_out;
    for (k = 0; k < 200; k++) begin
      @(posedge mclk);
      if (!last && ring_clock_out === 1'b1) begin
        if (s >= 0) break;
        s = k;
      end
      last = ring_clock_out;
    end
    if (k == 200) hang("divider");
    per = k - s;
  endtask

  task automatic phase_chk(input int ph);
    logic [7:0] h;
    int k;
    h = 8'h00;
    for (k = 0; k < 24; k++) begin
      @(posedge mclk);
      h = {h[6:0], ring_clock_out};
      if (k > 8) chk_word(ring_clock_out_shifted, h[ph], "shifted clock");
    end
  endtask

  initial begin
    repeat (10) @(posedge mclk);
    rstn <= 1'b1;
    rd(`ROSC_OFF_CTRL, {8'h00, `ROSC_EN_ENABLE, `ROSC_RANGE_RESET});
    chk_word(ring_ctrl, {1'b1, LEN_EIGHT, 24'h0}, "ring after reset");
    rd(`ROSC_OFF_DIV, {24'h0, `ROSC_DIV_RESET});
    rd(`ROSC_OFF_PAUSE, `ROSC_WAKE_KEY);
    repeat (25) @(posedge mclk);
    rd(`ROSC_OFF_STATUS, 32'h80001000);
    period(p);
    chk_word(p, 16, "reset divisor");
    phase_chk(0);
    // Low, medium and high range codes, raising one step at a time with the clock kept running
    // The overspeed code is never written by software
    for (n = 0; n < 3; n++) begin
      wr(`ROSC_OFF_CTRL, {8'h00, `ROSC_EN_ENABLE, codes[n]});
      chk_word(ring_ctrl.loop_length_select, lens[n], "loop length");
      period(p);
      chk_word(p, 16, "period after raise");
    end
    // Nothing in the bench is clocked by the ring, so lowering is safe here
    wr(`ROSC_OFF_CTRL, {8'h00, `ROSC_EN_ENABLE, `ROSC_RANGE_LOW});
    // Full loop, no bypassed stages; bench has no ring, so bit steps are lumped
    wr(`ROSC_OFF_DRVA, 32'h96967321);
    chk_word(ring_ctrl.drive[11:0], 12'hED1, "drive a");
    rd(`ROSC_OFF_DRVA, 32'h96967321);
    wr(`ROSC_OFF_DRVB, 32'h96967777);
    chk_word(ring_ctrl.drive, 24'hFFFED1, "drive b");
    wr(`ROSC_OFF_DRVB, 32'h12347777);
    chk_word(ring_ctrl.drive, 24'h000ED1, "drive without key");
    wr(`ROSC_OFF_DRVA, 32'h12340001);
    chk_word(ring_ctrl.drive, 24'h000000, "drive a without key");
    // Odd divisor checks the rounding of the high phase does not skew the period
    for (n = 0; n < 3; n++) begin
      wr(`ROSC_OFF_DIV, dv[n]);
      period(p);
      period(p);
      chk_word(p, dv[n], "divided period");
    end
    wr(`ROSC_OFF_PHASE, 32'h3);
    phase_chk(3);
    ring_sample_in <= 1'b1;
    repeat (4) @(posedge mclk);
    rd(`ROSC_OFF_RAND, 32'h1);
    ring_sample_in <= 1'b0;
    repeat (4) @(posedge mclk);
    rd(`ROSC_OFF_RAND, 32'h0);
    wr(`ROSC_OFF_COUNT, 32'h40);
    t0 = cyc;
    for (n = 0; n < 60; n++) begin
      axi_rd(`ROSC_OFF_COUNT, v, r);
      if (v === 32'h0) break;
    end
    chk_word((cyc - t0) >= 58 && (cyc - t0) <= 72, 1'b1, "countdown time");
    repeat (20) @(posedge mclk);
    rd(`ROSC_OFF_COUNT, 32'h0);
    axi_wr(8'h24, 32'hFFFFFFFF, r);
    chk_resp(r, `ROSC_RESP_SLVERR);
    axi_rd(8'h24, v, r);
    chk_resp(r, `ROSC_RESP_SLVERR);
    chk_word(v, 32'h0, "unmapped read");
    // A wrong pause code must not stop the ring
    wr(`ROSC_OFF_PAUSE, 32'h12345678);
    rd(`ROSC_OFF_PAUSE, `ROSC_WAKE_KEY);
    chk_word(ring_ctrl.enable, 1'b1, "enable after bad pause");
    axi_rd(`ROSC_OFF_STATUS, v, r);
    chk_word(v[`ROSC_ST_BADWR], 1'b1, "bad write flag");
    wr(`ROSC_OFF_STATUS, 32'h01000000);
    axi_rd(`ROSC_OFF_STATUS, v, r);
    chk_word(v[`ROSC_ST_BADWR], 1'b0, "bad write cleared");
    wr(`ROSC_OFF_CTRL, {8'h00, `ROSC_EN_DISABLE, `ROSC_RANGE_LOW});
    chk_word(ring_ctrl.enable, 1'b0, "disabled");
    axi_rd(`ROSC_OFF_STATUS, v, r);
    chk_word(v[`ROSC_ST_ENABLED], 1'b0, "enabled flag");
    wr(`ROSC_OFF_CTRL, {8'h00, 12'hFAC, `ROSC_RANGE_LOW});
    chk_word(ring_ctrl.enable, 1'b1, "invalid code enables");
    // Wake line is armed by the bench and no other clocks exist to move
    wr(`ROSC_OFF_PAUSE, `ROSC_PAUSE_KEY);
    chk_word(ring_ctrl.enable, 1'b0, "paused");
    axi_rd(`ROSC_OFF_STATUS, v, r);
    chk_word(v[`ROSC_ST_STABLE], 1'b0, "stable while paused");
    wake_irq_in <= 1'b1;
    t0 = cyc;
    for (n = 0; n < 40; n++) begin
      axi_rd(`ROSC_OFF_STATUS, v, r);
      if (v[`ROSC_ST_STABLE] === 1'b1) break;
    end
    p = cyc - t0;
    chk_word(p >= `ROSC_WAKE_CYC && p <= `ROSC_WAKE_CYC + 12, 1'b1, "wake time");
    chk_word(ring_ctrl.enable, 1'b1, "running after wake");
    wake_irq_in <= 1'b0;
    repeat (4) @(posedge mclk);
    conclude();
  end

  initial begin
    #2000000;
    hang("run");
  end
endmodule
